// ==== scale_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module scale_model
  import sp_pkg::*;
(
  // clock of the indicator
  input wire logic hclk,
  // scale path towards the engine
  output logic update_tick,
  output logic signed [VAL_W-1:0] gross_wt,
  output logic signed [VAL_W-1:0] net_wt,
  output logic signed [VAL_W-1:0] run_total,
  output logic signed [VAL_W-1:0] rate_value,
  output logic standstill
);
  // empty, moving scale until the bench loads a reading
  initial
  begin
    update_tick = 1'b0;
    gross_wt = '0;
    net_wt = '0;
    run_total = '0;
    rate_value = '0;
    standstill = 1'b0;
  end

  // a new reading lands just after an edge, always in primary units
  task automatic load(input int g, input int n, input int a, input int r, input logic s);
    @(posedge hclk);
    gross_wt <= 32'(g);
    net_wt <= 32'(n);
    run_total <= 32'(a);
    rate_value <= 32'(r);
    standstill <= s;
  endtask : load

  // one converter update; the wait covers a whole scan, closer ticks would be dropped
  task automatic convert();
    @(posedge hclk);
    update_tick <= 1'b1;
    @(posedge hclk);
    update_tick <= 1'b0;
    repeat (330) @(posedge hclk);
  endtask : convert
endmodule : scale_model
`default_nettype wire

// ==== setpoint_batch_engine.sv ====
// Notes on behaviour
// - one hundred setpoints, each drives an output
// - weight targets compared in primary units only
// - free-running setpoints re-evaluated every converter update
// - free-running output follows its condition, updated once per scan
// - sequence steps active one at a time
// - step output on until met, then latched
// - sequence runs only when enabled; auto or manual
// - start from input, serial, softkey or program
// - dual-use kinds join sequence only with flag
// - sequence-only kinds always act as steps
// - gross and net compare to positive target
// - negative kinds compare to negative target
// - running total compared with accumulated value
// - rate kind compares rate-of-change, not weight
// - offset above referenced target, its mode
// - offset below referenced target, its mode
// - percentage of referenced target value
// - percentage of referenced captured value
// - pause step waits for a new start
// - delay step waits value tenths of second
// - standstill step waits for scale standstill
// - sequence-running kind on while sequence runs
`timescale 1ns/1ps
`default_nettype none
module setpoint_batch_engine
  import sp_pkg::*;
#(
  parameter int unsigned N_SP = N_SETPOINTS,
  parameter int unsigned W = VAL_W,
  parameter int unsigned TENTH = TENTH_CYCLES
)
(
  // clock, reset, clock enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // scale path, same clock
  input wire logic update_tick,
  input wire logic signed [W-1:0] gross_wt,
  input wire logic signed [W-1:0] net_wt,
  input wire logic signed [W-1:0] run_total,
  input wire logic signed [W-1:0] rate_value,
  input wire logic standstill,
  // sequence start requests
  input wire logic start_din,
  input wire logic start_serial,
  input wire logic start_key,
  input wire logic start_prog,
  // outputs
  output logic [N_SP-1:0] sp_out,
  output logic seq_active
);
  localparam int unsigned EW = IDX_W + 5 + W;
  localparam logic [IDX_W-1:0] LAST = IDX_W'(N_SP - 1);

  typedef struct packed {
    logic en;
    logic auto_mode;
    logic [IDX_W-1:0] sel;
    logic [3:0] cfg_kind;
    logic cfg_batch;
    logic [IDX_W-1:0] cfg_ref;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic [2:0] din;
    logic start_pend;
    scan_e st;
    logic [IDX_W-1:0] idx;
    logic [EW-1:0] ent;
    logic wrap;
    logic running;
    logic step_done;
    logic [IDX_W-1:0] cur;
    logic have_first;
    logic [IDX_W-1:0] first;
    logic have_next;
    logic [IDX_W-1:0] next;
    logic [31:0] presc;
    logic [31:0] tenths;
    logic [N_SP-1:0] done;
    logic [N_SP-1:0] out;
  } eng_s;

  eng_s r;
  eng_s n;

  logic take;
  logic any_start;
  logic reg_start;
  logic launch;
  logic pause_go;
  logic consume;
  logic [EW-1:0] cfg_rd;
  logic signed [W-1:0] cap_rd;
  logic [IDX_W-1:0] raddr;
  logic cfg_we;
  logic cap_we;
  logic [EW-1:0] cfg_wdata;
  kind_e kind;
  logic signed [W-1:0] ent_val;
  logic is_seq;
  logic is_cur;
  logic hit;
  logic sat;
  logic signed [W-1:0] mode_wt;

  // bus request accepted in address phase; word transfers only
  assign take = hsel && hready && htrans[1] && (hsize == 3'h2);
  assign reg_start = r.ap_wr && (r.ap_addr == R_START) && hwdata[0];

  // every start source funnels into one pending flag
  assign any_start = reg_start || start_serial || start_key || start_prog
    || (r.din[1] && !r.din[2]);

  // entry fields of the setpoint being evaluated
  assign kind = kind_e'(r.ent[3:0]);
  assign ent_val = r.ent[E_VAL_LSB +: W];

  // dual-use kinds need their flag, pause/delay/standstill never do
  always_comb
  begin
    case (kind)
      K_PAUSE, K_DELAY, K_STILL: is_seq = 1'b1;
      K_GROSS, K_NET, K_NGROSS, K_NNET, K_TOTAL, K_RATE,
      K_RELP, K_RELN, K_PCTT, K_PCTC: is_seq = r.ent[E_BATCH];
      default: is_seq = 1'b0;
    endcase
  end

  // only the step the sequence points at is live
  assign is_cur = r.running && is_seq && (r.idx == r.cur);

  // what satisfies the current entry
  always_comb
  begin
    case (kind)
      K_PAUSE: sat = r.start_pend;
      K_DELAY: sat = r.tenths >= 32'(ent_val);
      K_STILL: sat = standstill;
      default: sat = hit;
    endcase
  end

  assign launch = r.wrap && r.en && !r.running && r.have_first
    && (r.auto_mode || r.start_pend);
  assign pause_go = (r.st == S_EVAL) && is_cur && (kind == K_PAUSE) && r.start_pend;
  assign consume = launch || pause_go;

  // reference entry is fetched in the cycle after its own entry
  assign raddr = (r.st == S_REF) ? cfg_rd[E_REF_LSB +: IDX_W] : r.idx;
  assign cfg_we = r.ap_wr && (r.ap_addr == R_VAL);
  assign cfg_wdata = {hwdata[W-1:0], r.cfg_ref, r.cfg_batch, r.cfg_kind};
  // a satisfied step records the weight it tripped at
  assign cap_we = (r.st == S_EVAL) && is_cur && sat;

  sp_table #(
    .DW(EW),
    .DEPTH(N_SP),
    .AW(IDX_W)
  ) u_cfg (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .we(cfg_we),
    .waddr(r.sel),
    .wdata(cfg_wdata),
    .raddr(raddr),
    .rdata(cfg_rd)
  );

  sp_table #(
    .DW(W),
    .DEPTH(N_SP),
    .AW(IDX_W)
  ) u_cap (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .we(cap_we),
    .waddr(r.idx),
    .wdata(mode_wt),
    .raddr(raddr),
    .rdata(cap_rd)
  );

  // weights arrive in primary units; no unit conversion here
  trip_compare #(
    .W(W)
  ) u_cmp (
    .kind(r.ent[3:0]),
    .value(ent_val),
    .ref_kind(cfg_rd[3:0]),
    .ref_value(cfg_rd[E_VAL_LSB +: W]),
    .ref_capture(cap_rd),
    .gross_wt(gross_wt),
    .net_wt(net_wt),
    .run_total(run_total),
    .rate_value(rate_value),
    .hit(hit),
    .mode_wt(mode_wt)
  );

  // next-state logic for the whole engine
  always_comb
  begin
    logic [31:0] rd;
    rd = '0;
    n = r;
    n.wrap = 1'b0;
    // address phase: read data is ready for the data phase
    n.ap_wr = take && hwrite;
    if (take)
      n.ap_addr = haddr[7:0];
    if (haddr[31:8] == 24'h0)
    begin
      case (haddr[7:0])
        R_CTRL: rd = {30'h0, r.auto_mode, r.en};
        R_STATUS: rd = {17'h0, r.cur, 5'h0, r.start_pend,
          r.en && !r.running && !r.auto_mode, r.running};
        R_SEL: rd = {25'h0, r.sel};
        R_CFG: rd = {17'h0, r.cfg_ref, 3'h0, r.cfg_batch, r.cfg_kind};
        default: rd = '0;
      endcase
    end
    if (take && !hwrite)
      n.rdata = rd;
    // data phase writes
    if (r.ap_wr)
    begin
      case (r.ap_addr)
        R_CTRL:
        begin
          n.en = hwdata[0];
          n.auto_mode = hwdata[1];
        end
        R_SEL: n.sel = hwdata[IDX_W-1:0];
        R_CFG:
        begin
          n.cfg_kind = hwdata[3:0];
          n.cfg_batch = hwdata[C_BATCH];
          n.cfg_ref = hwdata[C_REF_LSB +: IDX_W];
        end
        default: n.en = r.en;
      endcase
    end
    // pin start is asynchronous, so it passes two flops first
    n.din = {r.din[1:0], start_din};
    // a new request in the consuming cycle is kept
    n.start_pend = any_start || (r.start_pend && !consume);
    // tenths-of-second timer for the current step
    if (r.running)
    begin
      if (r.presc == 32'(TENTH - 1))
      begin
        n.presc = '0;
        n.tenths = r.tenths + 32'h1;
      end
      else
        n.presc = r.presc + 32'h1;
    end
    // end of a scan: move the sequence on
    if (r.wrap)
    begin
      if (!r.en)
      begin
        n.running = 1'b0;
        n.done = '0;
      end
      else if (r.running)
      begin
        if (r.step_done)
        begin
          n.presc = '0;
          n.tenths = '0;
          if (r.have_next)
            n.cur = r.next;
          else
          begin
            // whole sequence finished: latches drop
            n.done = '0;
            if (r.auto_mode && r.have_first)
              n.cur = r.first;
            else
              n.running = 1'b0;
          end
        end
      end
      else if (launch)
      begin
        n.running = 1'b1;
        n.cur = r.first;
        n.done = '0;
        n.presc = '0;
        n.tenths = '0;
      end
    end
    // scan all setpoints once per converter update
    case (r.st)
      S_IDLE:
      begin
        if (update_tick)
        begin
          n.st = S_ENTRY;
          n.idx = '0;
          n.step_done = 1'b0;
          n.have_first = 1'b0;
          n.have_next = 1'b0;
        end
      end
      S_ENTRY: n.st = S_REF;
      S_REF:
      begin
        n.ent = cfg_rd;
        n.st = S_EVAL;
      end
      S_EVAL:
      begin
        if (is_seq)
        begin
          if (!r.have_first)
          begin
            n.have_first = 1'b1;
            n.first = r.idx;
          end
          if (!r.have_next && r.idx > r.cur)
          begin
            n.have_next = 1'b1;
            n.next = r.idx;
          end
          // on while pending, held off once met
          n.out[r.idx] = is_cur && !sat && !r.done[r.idx];
          if (is_cur && sat)
          begin
            n.done[r.idx] = 1'b1;
            n.step_done = 1'b1;
          end
        end
        else if (kind == K_SEQRUN)
          n.out[r.idx] = r.running;
        else
          n.out[r.idx] = hit;
        if (r.idx == LAST)
        begin
          n.st = S_IDLE;
          n.wrap = 1'b1;
        end
        else
        begin
          n.idx = r.idx + 1'b1;
          n.st = S_ENTRY;
        end
      end
      default: n.st = S_IDLE;
    endcase
  end

  // one register for all state; ce freezes everything
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r <= '0;
      r.st <= S_IDLE;
      {r.auto_mode, r.en} <= CTRL_RST;
    end
    else if (ce)
      r <= n;
  end

  // zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign sp_out = r.out;
  assign seq_active = r.running;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_free_follow: assert property (
    (ce && r.st == S_EVAL && !is_seq && kind != K_SEQRUN)
    |=> r.out[$past(r.idx)] == $past(hit))
    else $error("free-running output did not follow condition");

  a_one_step: assert property (
    (ce && r.st == S_EVAL && is_seq && !is_cur) |=> !r.out[$past(r.idx)])
    else $error("non-current step output active");

  a_latch_met: assert property (
    (ce && r.st == S_EVAL && is_cur && sat)
    |=> r.done[$past(r.idx)] && !r.out[$past(r.idx)])
    else $error("met step not latched");

  a_seq_gate: assert property (
    (ce && r.wrap && !r.en) |=> !r.running)
    else $error("sequence runs while disabled");

  a_manual_wait: assert property (
    (ce && r.wrap && !r.running && !r.auto_mode && !r.start_pend) |=> !r.running)
    else $error("manual sequence started without request");

  a_start_kept: assert property (
    (ce && any_start) |=> r.start_pend)
    else $error("start request lost");

  a_pause_hold: assert property (
    (ce && r.st == S_EVAL && is_cur && kind == K_PAUSE && !r.start_pend)
    |=> $stable(r.step_done))
    else $error("pause step advanced without start");

  a_delay_wait: assert property (
    (ce && r.st == S_EVAL && is_cur && kind == K_DELAY && r.tenths < 32'(ent_val))
    |=> $stable(r.step_done))
    else $error("delay step ended early");

  a_still_wait: assert property (
    (ce && r.st == S_EVAL && is_cur && kind == K_STILL && !standstill)
    |=> $stable(r.step_done))
    else $error("standstill step passed in motion");

  a_run_out: assert property (
    (ce && r.st == S_EVAL && kind == K_SEQRUN)
    |=> r.out[$past(r.idx)] == $past(r.running))
    else $error("sequence-running output wrong");

  a_advance: assert property (
    (ce && r.wrap && r.en && r.running && r.step_done && r.have_next)
    |=> r.cur == $past(r.next) ##1 r.running)
    else $error("sequence did not advance");
endmodule : setpoint_batch_engine
`default_nettype wire

// ==== sp_pkg.sv ====
`default_nettype none
package sp_pkg;
  // table geometry
  localparam int unsigned N_SETPOINTS = 100;
  localparam int unsigned VAL_W = 32;
  localparam int unsigned IDX_W = 7;
  localparam int unsigned ENT_W = 44;
  // entry layout: {value, ref, batch, kind}
  localparam int unsigned E_BATCH = 4;
  localparam int unsigned E_REF_LSB = 5;
  localparam int unsigned E_VAL_LSB = 12;
  // configuration word layout as software sees it
  localparam int unsigned C_BATCH = 4;
  localparam int unsigned C_REF_LSB = 8;
  localparam int unsigned ST_CUR_LSB = 8;
  // register byte offsets
  localparam logic [7:0] R_CTRL = 8'h00;
  localparam logic [7:0] R_START = 8'h04;
  localparam logic [7:0] R_STATUS = 8'h08;
  localparam logic [7:0] R_SEL = 8'h0c;
  localparam logic [7:0] R_CFG = 8'h10;
  localparam logic [7:0] R_VAL = 8'h14;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // delay steps count tenths of a second
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned TENTH_NS = 100_000_000;
  localparam int unsigned TENTH_CYCLES = TENTH_NS / CLK_NS;
  localparam int PCT_SCALE = 100;
  // setpoint kinds
  typedef enum logic [3:0] {
    K_OFF = 4'h0, K_GROSS = 4'h1, K_NET = 4'h2, K_NGROSS = 4'h3,
    K_NNET = 4'h4, K_TOTAL = 4'h5, K_RATE = 4'h6, K_RELP = 4'h7,
    K_RELN = 4'h8, K_PCTT = 4'h9, K_PCTC = 4'ha, K_PAUSE = 4'hb,
    K_DELAY = 4'hc, K_STILL = 4'hd, K_SEQRUN = 4'he
  } kind_e;
  // scan sequencer
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_ENTRY = 2'b01, S_REF = 2'b10, S_EVAL = 2'b11
  } scan_e;
endpackage : sp_pkg
`default_nettype wire

// ==== sp_table.sv ====
`timescale 1ns/1ps
`default_nettype none
module sp_table
  import sp_pkg::*;
#(
  parameter int unsigned DW = ENT_W,
  parameter int unsigned DEPTH = N_SETPOINTS,
  parameter int unsigned AW = IDX_W
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // registered read port
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0] rd;
  } tbl_s;
  tbl_s r;
  tbl_s n;

  // read before write: a same-address read sees the old word
  always_comb
  begin
    n = r;
    if (raddr < DEPTH)
      n.rd = r.mem[raddr];
    else
      n.rd = '0;
    if (we && waddr < DEPTH)
      n.mem[waddr] = wdata;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r <= '0;
    else if (ce)
      r <= n;
  end

  assign rdata = r.rd;
endmodule : sp_table
`default_nettype wire

// ==== test_setpoint_batch_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_setpoint_batch_engine;
  import sp_pkg::*;
  // short tenth of a second so delay steps span about one scan
  localparam int unsigned TEN = 200;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, seq_active;
  logic start_din, start_serial, start_key, start_prog;
  logic update_tick, standstill;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic signed [VAL_W-1:0] gross_wt, net_wt, run_total, rate_value;
  logic [N_SETPOINTS-1:0] sp_out;
  int err_count = 0;
  int checked = 0;
  // free-running stages: gross, net, total, rate, expected outputs 8..0
  int wg[3] = '{150, -150, 90};
  int wn[3] = '{-150, 150, 150};
  int wa[3] = '{200, 50, 50};
  int wr[3] = '{50, 150, 150};
  logic [8:0] we[3] = '{9'h1d9, 9'h026, 9'h1a2};
  // sequence walk: gross, outputs {16,15,14,10}, current step
  int sg[11] = '{0, 150, 0, 0, 0, 0, 0, 60, 60, 90, 90};
  logic [3:0] so[11] = '{4'h3, 4'h6, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'ha, 4'h2, 4'h0};
  int sc[11] = '{10, 11, 11, 12, 12, 13, 13, 16, 16, 0, 0};

  setpoint_batch_engine #(.TENTH(TEN)) uut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .update_tick(update_tick), .gross_wt(gross_wt), .net_wt(net_wt),
    .run_total(run_total), .rate_value(rate_value), .standstill(standstill),
    .start_din(start_din), .start_serial(start_serial), .start_key(start_key),
    .start_prog(start_prog), .sp_out(sp_out), .seq_active(seq_active));

  scale_model scale (.hclk(hclk), .update_tick(update_tick), .gross_wt(gross_wt),
    .net_wt(net_wt), .run_total(run_total), .rate_value(rate_value),
    .standstill(standstill));

  // 250 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask : check

  // one single word transfer; the address phase is held until hready is seen
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask : bus

  task automatic st(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd & mask, e);
  endtask : st

  // select, configure, then commit with the value write
  task automatic set_sp(input int i, input logic [3:0] k, input int b, input int r, input int v);
    bus(1'b1, R_SEL, 32'(i));
    bus(1'b1, R_CFG, (32'(r) << C_REF_LSB) | (32'(b) << C_BATCH) | 32'(k));
    bus(1'b1, R_VAL, 32'(v));
  endtask : set_sp

  // start request; the pin is held for several cycles since it is synchronised
  task automatic pulse(input int w);
    @(posedge hclk);
    case (w)
      0: start_key <= 1'b1;
      1: start_serial <= 1'b1;
      2: start_prog <= 1'b1;
      default: start_din <= 1'b1;
    endcase
    @(posedge hclk);
    start_key <= 1'b0;
    start_serial <= 1'b0;
    start_prog <= 1'b0;
    repeat (4) @(posedge hclk);
    start_din <= 1'b0;
  endtask : pulse

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // watchdog, well above the roughly 6700 cycles the tests take
  initial
  begin
    repeat (40000) @(posedge hclk);
    err_count++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    start_din = 1'b0;
    start_serial = 1'b0;
    start_key = 1'b0;
    start_prog = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    check({hresp, seq_active, sp_out}, 0);
    check(hreadyout, 1'b1);
    st(R_CTRL, 32'hffffffff, 32'h0);
    st(R_STATUS, 32'hffffffff, 32'h0);
    st(8'h40, 32'hffffffff, 32'h0);
    bus(1'b1, R_SEL, 32'h63);
    st(R_SEL, 32'h7f, 32'h63);
    $display("test reset and registers done");
    // free-running kinds, all with the sequence flag off, kept out of any sequence
    for (int i = 0; i < 6; i++)
      set_sp(i, 4'(i + 1), 0, 0, 100);
    set_sp(6, K_RELP, 0, 0, 20);
    set_sp(7, K_RELN, 0, 0, 20);
    set_sp(8, K_PCTT, 0, 0, 50);
    st(R_CFG, 32'hffffffff, 32'h9);
    for (int s = 0; s < 3; s++)
    begin
      scale.load(wg[s], wn[s], wa[s], wr[s], 1'b0);
      scale.convert();
      check(sp_out, we[s]);
    end
    $display("test free-running kinds done");
    // sequence 10 gross, pause, delay, wait, 16 percent of capture; 14 and 15 run free
    for (int i = 0; i < 9; i++)
      set_sp(i, K_OFF, 0, 0, 0);
    set_sp(10, K_GROSS, 1, 0, 100);
    set_sp(11, K_PAUSE, 0, 0, 0);
    set_sp(12, K_DELAY, 0, 0, 1);
    set_sp(13, K_STILL, 0, 0, 0);
    set_sp(14, K_SEQRUN, 0, 0, 0);
    set_sp(15, K_GROSS, 0, 0, 100);
    set_sp(16, K_PCTC, 1, 10, 50);
    scale.load(0, 0, 0, 0, 1'b0);
    bus(1'b1, R_CTRL, 32'h1);
    scale.convert();
    st(R_STATUS, 32'h7, 32'h2);
    check(seq_active, 1'b0);
    pulse(2);
    st(R_STATUS, 32'h4, 32'h4);
    scale.convert();
    st(R_STATUS, 32'h7f07, 32'h0a01);
    for (int s = 0; s < 11; s++)
    begin
      scale.load(sg[s], 0, 0, 0, s >= 7);
      if (s == 3)
        pulse(3);
      scale.convert();
      check({sp_out[16:14], sp_out[10]}, so[s]);
      st(R_STATUS, (s < 9) ? 32'h7f01 : 32'h1, (32'(sc[s]) << ST_CUR_LSB) | 32'(s < 9));
      check(seq_active, s < 9);
    end
    $display("test manual sequence done");
    // automatic selection starts with no request; disabling stops it
    bus(1'b1, R_CTRL, 32'h3);
    scale.convert();
    check(seq_active, 1'b1);
    bus(1'b1, R_CTRL, 32'h0);
    scale.convert();
    check(seq_active, 1'b0);
    bus(1'b1, R_CTRL, 32'h1);
    pulse(1);
    scale.convert();
    check(seq_active, 1'b1);
    bus(1'b1, R_START, 32'h1);
    st(R_STATUS, 32'h5, 32'h5);
    pulse(0);
    st(R_STATUS, 32'h5, 32'h5);
    $display("test auto and start sources done");
    tally_and_finish();
  end
endmodule : test_setpoint_batch_engine
`default_nettype wire

// ==== trip_compare.sv ====
`timescale 1ns/1ps
`default_nettype none
module trip_compare
  import sp_pkg::*;
#(
  parameter int unsigned W = VAL_W
)
(
  // setpoint and its reference
  input wire logic [3:0] kind,
  input wire logic signed [W-1:0] value,
  input wire logic [3:0] ref_kind,
  input wire logic signed [W-1:0] ref_value,
  input wire logic signed [W-1:0] ref_capture,
  // scale data, primary units
  input wire logic signed [W-1:0] gross_wt,
  input wire logic signed [W-1:0] net_wt,
  input wire logic signed [W-1:0] run_total,
  input wire logic signed [W-1:0] rate_value,
  // result
  output logic hit,
  output logic signed [W-1:0] mode_wt
);
  localparam int XW = 2 * W + 8;
  logic ref_gross;
  logic ref_neg;
  logic signed [W-1:0] rw;
  logic signed [XW-1:0] lhs;
  logic signed [XW-1:0] thr;
  logic signed [XW-1:0] base;

  // relative kinds borrow the weight mode of the referenced setpoint
  always_comb
  begin
    ref_gross = (ref_kind == K_GROSS) || (ref_kind == K_NGROSS);
    ref_neg = (ref_kind == K_NGROSS) || (ref_kind == K_NNET);
    rw = ref_gross ? gross_wt : net_wt;
    lhs = XW'(rw);
    thr = '0;
    base = (kind == K_PCTC) ? XW'(ref_capture) : XW'(ref_value);
    hit = 1'b0;
    mode_wt = rw;
    case (kind)
      K_GROSS:
      begin
        hit = gross_wt >= value;
        mode_wt = gross_wt;
      end
      K_NET:
      begin
        hit = net_wt >= value;
        mode_wt = net_wt;
      end
      K_NGROSS:
      begin
        hit = gross_wt <= -value;
        mode_wt = gross_wt;
      end
      K_NNET:
      begin
        hit = net_wt <= -value;
        mode_wt = net_wt;
      end
      K_TOTAL:
      begin
        hit = run_total >= value;
        mode_wt = run_total;
      end
      K_RATE:
      begin
        hit = rate_value >= value;
        mode_wt = rate_value;
      end
      K_RELP, K_RELN:
      begin
        // magnitudes grow away from zero for negative reference modes
        if (kind == K_RELP)
          thr = XW'(ref_value) + XW'(value);
        else
          thr = XW'(ref_value) - XW'(value);
        hit = ref_neg ? (lhs <= -thr) : (lhs >= thr);
      end
      K_PCTT, K_PCTC:
      begin
        // cross-multiplied so no divider is needed
        lhs = XW'(rw) * XW'(PCT_SCALE);
        thr = base * XW'(value);
        hit = ref_neg ? (lhs <= -thr) : (lhs >= thr);
      end
      default: hit = 1'b0;
    endcase
  end
endmodule : trip_compare
`default_nettype wire
